// *** logic/oss_params.svh ***
// What this block does
// - chip select low enables transfers and output
// - shifted command applied at chip select rise
// - input bit sampled on falling serial clock
// - output bit advanced on rising serial clock
// - select high ignores clock, output tri-state
// - sixteen bit frames, msb first, fifo
// - one turns output on, zero off
// - status one on fault, zero normal
// - off with detect disabled reports zero
// - eight leading zeros, then status 8..1
// - drivers and faults only while enabled
// - enable low forces outputs and currents off
// - enable rise resets internal state
// - supply application resets internal state
// - outputs five and six ORed with pwm
// - daisy chain passes bits, loads at rise
// - reset leaves outputs off, detect disabled
// - bits 15..8 enable detect currents 8..1
// - fault must persist fault time first
`ifndef OSS_PARAMS_SVH
`define OSS_PARAMS_SVH
`define OSS_FRAME_BITS     16
`define OSS_CH             8
`define OSS_DETECT_LSB     8
`define OSS_CMD_RESET      16'h0000
`define OSS_CLK_MHZ        25
`define OSS_FAULT_US       300
`define OSS_FAULT_CYC      (`OSS_FAULT_US * `OSS_CLK_MHZ)
`endif

// *** logic/oss_pkg.sv ***
package oss_pkg;
  typedef logic [15:0] oss_word_t;
  typedef logic [7:0]  oss_ch_t;
endpackage

// *** logic/oss_sync.sv ***
`timescale 1ns/1ps
module oss_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic d,
  output logic      q
);
  logic meta_reg;
  // two-stage synchroniser
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= 1'b0;
      q        <= 1'b0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// *** logic/oss_fault_filter.sv ***
`timescale 1ns/1ps
`include "oss_params.svh"
module oss_fault_filter #(
  parameter int FAULT_CYC = `OSS_FAULT_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic raw,
  output logic      flag
);
  logic [31:0] cnt_reg;
  // flag rises only after raw fault persists
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 32'h0;
      flag    <= 1'b0;
    end else if (!raw) begin
      cnt_reg <= 32'h0;
      flag    <= 1'b0;
    end else if (cnt_reg >= 32'(FAULT_CYC - 1)) begin
      flag    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
    end
  end
endmodule

// *** logic/oss_top.sv ***
`timescale 1ns/1ps
`include "oss_params.svh"
module oss_top #(
  parameter int FAULT_CYC = `OSS_FAULT_CYC
) (
  input  wire logic            clk,
  input  wire logic            sys_rst,
  input  wire logic            sclk,
  input  wire logic            cs_n,
  input  wire logic            serial_cmd_in,
  output logic                 serial_out,
  output logic                 serial_out_oe,
  input  wire logic            enable_in,
  input  wire logic            logic_supply_ok,
  input  wire logic            battery_supply,
  input  wire logic            direct_pwm_in_a,
  input  wire logic            direct_pwm_in_b,
  input  wire oss_pkg::oss_ch_t raw_fault,
  output oss_pkg::oss_ch_t     out_on,
  output oss_pkg::oss_ch_t     detect_on
);
  import oss_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // supply and enable resets
  logic en_s;
  logic lsup_s;
  logic bat_s;
  logic pwm_a_s;
  logic pwm_b_s;
  logic en_d_reg;
  logic lsup_d_reg;
  logic bat_d_reg;
  logic por_reg;

  oss_sync u_sync_en   (.clk(clk), .rst(sys_rst), .d(enable_in),       .q(en_s));
  oss_sync u_sync_lsup (.clk(clk), .rst(sys_rst), .d(logic_supply_ok), .q(lsup_s));
  oss_sync u_sync_bat  (.clk(clk), .rst(sys_rst), .d(battery_supply),  .q(bat_s));
  oss_sync u_sync_pa   (.clk(clk), .rst(sys_rst), .d(direct_pwm_in_a), .q(pwm_a_s));
  oss_sync u_sync_pb   (.clk(clk), .rst(sys_rst), .d(direct_pwm_in_b), .q(pwm_b_s));

  wire en_rise   = en_s & ~en_d_reg;
  wire sup_rise  = (lsup_s & ~lsup_d_reg) | (bat_s & ~bat_d_reg);
  wire por_next  = en_rise | sup_rise | ~en_s;

  // edge detectors on synchronised levels
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      en_d_reg   <= 1'b0;
      lsup_d_reg <= 1'b0;
      bat_d_reg  <= 1'b0;
      por_reg    <= 1'b1;
    end else begin
      en_d_reg   <= en_s;
      lsup_d_reg <= lsup_s;
      bat_d_reg  <= bat_s;
      por_reg    <= por_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link domain: serial shift logic on sclk
  oss_word_t shift_reg;
  logic      out_bit_reg;
  logic      frame_tog_reg;
  oss_word_t status_word;
  oss_ch_t   fault_hold;
  oss_ch_t   fault_flags_q;

  // status captured at select fall, leading eight bits zero
  assign status_word = {8'h00, fault_hold};

  // sample input on falling sclk; clear to zero while select is high
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      shift_reg <= `OSS_CMD_RESET;
    end else begin
      shift_reg <= {shift_reg[14:0], serial_cmd_in};
    end
  end

  // output msb first; first bit presented before first rising edge
  logic [3:0] tx_cnt_reg;
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      tx_cnt_reg <= 4'h0;
    end else begin
      tx_cnt_reg <= tx_cnt_reg + 4'h1;
    end
  end

  // daisy chain: after sixteen bits the received command passes on
  logic [4:0] rx_cnt_reg;
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      rx_cnt_reg <= 5'h00;
    end else if (rx_cnt_reg != 5'h10) begin
      rx_cnt_reg <= rx_cnt_reg + 5'h01;
    end
  end

  wire pass_mode = (rx_cnt_reg == 5'h10);
  wire tx_bit    = pass_mode ? shift_reg[15] : status_word[4'hf - tx_cnt_reg];

  // output bit registered on rising sclk; cleared value equals status bit 15, always zero
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      out_bit_reg <= 1'b0;
    end else begin
      out_bit_reg <= tx_bit;
    end
  end

  // capture applied command into a link-side holding register at select rise
  oss_word_t cmd_hold_reg;
  always_ff @(posedge cs_n or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_hold_reg  <= `OSS_CMD_RESET;
      frame_tog_reg <= 1'b0;
    end else begin
      cmd_hold_reg  <= shift_reg;
      frame_tog_reg <= ~frame_tog_reg;
    end
  end

  // status snapshot at select fall
  logic [7:0] snap_reg;
  always_ff @(negedge cs_n) begin
    snap_reg <= fault_flags_q;
  end
  assign fault_hold = snap_reg;

  ////////////////////////////////////////////////////////////////////////////
  // frame toggle crossing into clk domain
  logic tog_s;
  logic tog_d_reg;
  oss_sync u_sync_tog (.clk(clk), .rst(sys_rst), .d(frame_tog_reg), .q(tog_s));
  wire frame_done = tog_s ^ tog_d_reg;

  oss_word_t cmd_reg;
  oss_word_t cmd_next;
  // command stable by the time toggle arrives two cycles later
  assign cmd_next = por_reg ? `OSS_CMD_RESET : (frame_done ? cmd_hold_reg : cmd_reg);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tog_d_reg <= 1'b0;
      cmd_reg   <= `OSS_CMD_RESET;
    end else begin
      tog_d_reg <= tog_s;
      cmd_reg   <= cmd_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output drive and fault qualification
  oss_ch_t on_cmd;
  oss_ch_t on_next;
  oss_ch_t det_next;
  oss_ch_t raw_q;

  // outputs five and six ORed with direct pwm inputs
  assign on_cmd   = {cmd_reg[7:6], cmd_reg[5] | pwm_b_s, cmd_reg[4] | pwm_a_s, cmd_reg[3:0]};
  assign on_next  = en_s ? on_cmd : 8'h00;
  assign det_next = en_s ? cmd_reg[15:8] : 8'h00;
  // off with detect disabled never faults; disabled device never reports
  // raw_q is the per-channel fault mask; raw faults enter only through synchronisers
  assign raw_q    = en_s ? (on_next | det_next) : 8'h00;

  genvar gi;
  generate
    for (gi = 0; gi < `OSS_CH; gi++) begin : g_flt
      logic rs;
      oss_sync u_rs (.clk(clk), .rst(sys_rst), .d(raw_fault[gi]), .q(rs));
      oss_fault_filter #(.FAULT_CYC(FAULT_CYC)) u_ff (
        .clk  (clk),
        .rst  (sys_rst),
        .raw  (rs & raw_q[gi]),
        .flag (fault_flags_q[gi])
      );
    end
  endgenerate

  // registered outputs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_on    <= 8'h00;
      detect_on <= 8'h00;
    end else begin
      out_on    <= on_next;
      detect_on <= det_next;
    end
  end

  // serial output pin and enable follow select
  assign serial_out    = out_bit_reg;
  assign serial_out_oe = ~cs_n;

  ////////////////////////////////////////////////////////////////////////////
  // assertions and covers on the system clock
  sleep_outputs_off_a:
    assert property (@(posedge clk) disable iff (sys_rst) !en_s |=> (out_on == 8'h00))
    else $error("outputs on while asleep");
  sleep_detect_off_a:
    assert property (@(posedge clk) disable iff (sys_rst) !en_s |=> (detect_on == 8'h00))
    else $error("detect current on while asleep");
  cmd_hold_idle_a:
    assert property (@(posedge clk) disable iff (sys_rst) (!frame_done && !por_reg) |=> $stable(cmd_reg))
    else $error("command changed without a frame");
  pwm_a_or_a:
    assert property (@(posedge clk) disable iff (sys_rst) (en_s && pwm_a_s) |=> out_on[4])
    else $error("output five off with pwm input high");
  pwm_b_or_a:
    assert property (@(posedge clk) disable iff (sys_rst) (en_s && pwm_b_s) |=> out_on[5])
    else $error("output six off with pwm input high");
  status_masked_a:
    assert property (@(posedge clk) disable iff (sys_rst) ((fault_flags_q & ~$past(raw_q)) == 8'h00))
    else $error("fault reported on masked channel");
  frame_applied_c: cover property (@(posedge clk) disable iff (sys_rst) frame_done && !por_reg);
  enable_reset_c:  cover property (@(posedge clk) disable iff (sys_rst) en_rise);
  fault_seen_c:    cover property (@(posedge clk) disable iff (sys_rst) fault_flags_q != 8'h00);
endmodule

// *** testbench/oss_spi_master.sv ***
`timescale 1ns/1ps
// spi master model: clock idles low and stands still between frames
module oss_spi_master (
  output logic      sclk,
  output logic      cs_n,
  output logic      serial_cmd_in,
  input  wire logic serial_out
);
  import oss_pkg::*;
  // idle levels at time zero
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    serial_cmd_in = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // one frame of 160 ns bits, msb first, clock low at select edges
  task automatic xfer(input oss_word_t tx, output oss_word_t rx);
    cs_n = 1'b0;
    #60;
    for (int i = 15; i >= 0; i--) begin
      serial_cmd_in = tx[i];
      #40 sclk = 1'b1;
      #80 sclk = 1'b0;
      #20 serial_cmd_in = ~tx[i]; // hold time over, show the inverse
      #20 rx[i] = serial_out;
    end
    #40 cs_n = 1'b1;
  endtask
endmodule

// *** testbench/octal_switch_serial_control_test.sv ***
`timescale 1ns/1ps
module octal_switch_serial_control_test;
  import oss_pkg::*;
  logic      clk = 1'b0;
  logic      sys_rst = 1'b1;
  logic      sclk, cs_n, serial_cmd_in, serial_out, serial_out_oe;
  logic      enable_in = 1'b1, logic_supply_ok = 1'b1, battery_supply = 1'b1;
  logic      direct_pwm_in_a = 1'b0, direct_pwm_in_b = 1'b0;
  oss_ch_t   raw_fault = 8'h00;
  oss_ch_t   out_on, detect_on;
  oss_word_t rx;
  int        n_fail = 0;
  int        comparisons = 0;
  // 25 mhz system clock
  always #20 clk = ~clk;
  oss_top #(.FAULT_CYC(4)) i_oss_top (.clk(clk), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n),
    .serial_cmd_in(serial_cmd_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .enable_in(enable_in), .logic_supply_ok(logic_supply_ok), .battery_supply(battery_supply),
    .direct_pwm_in_a(direct_pwm_in_a), .direct_pwm_in_b(direct_pwm_in_b), .raw_fault(raw_fault),
    .out_on(out_on), .detect_on(detect_on));
  oss_spi_master i_oss_spi_master (.sclk(sclk), .cs_n(cs_n), .serial_cmd_in(serial_cmd_in),
    .serial_out(serial_out));
  ////////////////////////////////////////////////////////////////
  // word compare
  task automatic chk(input oss_word_t got, input oss_word_t exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one frame, then wait past the apply latency
  task automatic frame(input oss_word_t tx);
    i_oss_spi_master.xfer(tx, rx);
    wait_clk(8);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    wait_clk(5);
    sys_rst <= 1'b0;
    wait_clk(4);
    chk({out_on, detect_on}, 16'h0000);
    chk({15'h0000, serial_out_oe}, 16'h0000);
    $display("reset test done");
    frame(16'ha53c);
    chk(rx, 16'h0000);
    chk({detect_on, out_on}, 16'ha53c);
    $display("command test done");
    raw_fault <= 8'h83;
    frame(16'h8002);
    wait_clk(20);
    frame(16'h8002);
    chk(rx, 16'h0082);
    $display("fault test done");
    raw_fault <= 8'h00;
    direct_pwm_in_a <= 1'b1;
    frame(16'h0001);
    chk({8'h00, out_on}, 16'h0011);
    direct_pwm_in_b <= 1'b1;
    wait_clk(8);
    chk({8'h00, out_on}, 16'h0031);
    $display("pwm test done");
    enable_in <= 1'b0;
    wait_clk(8);
    chk({out_on, detect_on}, 16'h0000);
    enable_in <= 1'b1;
    direct_pwm_in_a <= 1'b0;
    direct_pwm_in_b <= 1'b0;
    wait_clk(8);
    chk({out_on, detect_on}, 16'h0000);
    frame(16'h00ff);
    chk({out_on, detect_on}, 16'hff00);
    battery_supply <= 1'b0;
    wait_clk(4);
    battery_supply <= 1'b1;
    wait_clk(8);
    chk({out_on, detect_on}, 16'h0000);
    $display("enable and supply test done");
    give_verdict();
  end
  // watchdog against a hang
  initial begin
    #200000;
    n_fail++;
    give_verdict();
  end
endmodule
